// ### pllc_pkg.sv
// shared constants, register map and state types of the pll planning controller
package pllc_pkg;

    // =====================================================================
    // timing
    localparam int CLOCK_MHZ = 32'h19;
    localparam int POR_TIME_US = 32'hFA;
    localparam int POR_CYCLES = POR_TIME_US * CLOCK_MHZ;
    localparam int CAL_TIME_US = 32'h28;
    localparam int CAL_CYCLES = CAL_TIME_US * CLOCK_MHZ;
    localparam int TIMER_W = 16;

    // =====================================================================
    // frequency plan limits
    localparam logic [31:0] HZ_PER_MHZ = 32'hF4240;
    localparam logic [15:0] VCO_MIN_MHZ = 16'hD16;
    localparam logic [15:0] VCO_MAX_MHZ = 16'hFD2;
    localparam logic [15:0] PFD_MIN_HZ = 16'h33F4;
    localparam logic [7:0] PFD_MAX_MHZ = 8'h64;
    localparam logic [7:0] CRYSTAL_INPUT_MHZ = 8'h19;
    localparam logic [7:0] HOLD_PFD_MAX_MHZ = 8'h32;
    localparam logic [3:0] K_DENOM = 4'h5;
    localparam logic [3:0] P0_MIN = 4'h5;
    localparam logic [3:0] P0_MAX = 4'hB;
    localparam logic [20:0] N_MIN = 21'h20;
    localparam logic [20:0] N_FULL = 21'h100000;
    localparam logic [14:0] R_FULL = 15'h4000;

    // input path scale factor codes: numerator over K_DENOM
    localparam logic [1:0] K_FIFTH = 2'h0;
    localparam logic [1:0] K_TWO_FIFTHS = 2'h1;
    localparam logic [1:0] K_ONE = 2'h2;
    localparam logic [1:0] K_TWO = 2'h3;

    // =====================================================================
    // register map (word index) and field positions
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PDIV = 4'h1;
    localparam logic [3:0] ADDR_NDIV = 4'h2;
    localparam logic [3:0] ADDR_RDIV = 4'h3;
    localparam logic [3:0] ADDR_XODIV = 4'h4;
    localparam logic [3:0] ADDR_FREF = 4'h5;
    localparam logic [3:0] ADDR_FOUT = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_PINS = 4'h8;
    localparam int CTRL_HOLD_POS = 2;
    localparam int PDIV_P1_POS = 8;

    // =====================================================================
    // synchronised pin vector layout
    localparam int SYNC_W = 14;
    localparam int SYNC_RST = 0;
    localparam int SYNC_PRIMARY_REFERENCE_INPUT = 1;
    localparam int SYNC_CRYSTAL_INPUT = 3;
    localparam int SYNC_SEL = 4;

    // =====================================================================
    // types
    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_HOLD = 5'h02,
        ST_CAL = 5'h04,
        ST_LOCK = 5'h08,
        ST_FAIL = 5'h10
    } pllc_state_type;

    typedef struct packed {
        logic [1:0] k_sel;
        logic holdover;
        logic [3:0] p0;
        logic [5:0] p1;
        logic [19:0] n;
        logic [13:0] r;
        logic [13:0] rxo;
        logic [29:0] fref;
        logic [29:0] fout;
    } pllc_plan_type;

    typedef struct packed {
        logic k_ok;
        logic p0_ok;
        logic p1_ok;
        logic n_ok;
        logic vco_ok;
        logic pfd_ok;
        logic exact_ok;
        logic xo_ok;
        logic legal;
    } pllc_check_type;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        pllc_plan_type plan;
        pllc_state_type state;
        logic [TIMER_W-1:0] timer;
        logic [9:0] sel_cap;
        logic pins_changed;
        logic cal_busy;
        logic cal_fail;
        logic locked;
        logic in_reset;
        logic [31:0] rdata;
    } pllc_core_type;

    // reset values: worked 125 MHz in, 155.52 MHz out plan
    localparam pllc_plan_type PLAN_RESET = '{
        k_sel: K_TWO_FIFTHS,
        holdover: 1'b0,
        p0: 4'h6,
        p1: 6'h04,
        n: 20'h38F40,
        r: 14'h0C35,
        rxo: 14'h0C35,
        fref: 30'h07735940,
        fout: 30'h09450C00
    };

    localparam pllc_core_type CORE_RESET = '{
        sync1: '0,
        sync2: '0,
        plan: PLAN_RESET,
        state: ST_POR,
        timer: '0,
        sel_cap: '0,
        pins_changed: 1'b0,
        cal_busy: 1'b0,
        cal_fail: 1'b0,
        locked: 1'b0,
        in_reset: 1'b1,
        rdata: '0
    };

endpackage

// ### pllc_plan_check.sv
// legality checker for the divider plan, one registered result per cycle
`timescale 1ns/1ps
module pllc_plan_check
    import pllc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // plan in, verdict out
    input wire pllc_plan_type i_plan,
    output pllc_check_type o_check
);

    pllc_check_type q;
    pllc_check_type d;
    logic [63:0] knum;
    logic [63:0] nval;
    logic [63:0] rval;
    logic [63:0] vco;
    logic [63:0] ref_k;
    logic [63:0] pfd_top;

    // =====================================================================
    // verdict
    always_comb
    begin
        case (i_plan.k_sel)
            K_FIFTH: knum = 64'h1;
            K_TWO_FIFTHS: knum = 64'h2;
            K_ONE: knum = 64'(K_DENOM);
            default: knum = 64'hA;
        endcase
        // a zero field stands for the full divider range
        nval = (i_plan.n == '0) ? 64'(N_FULL) : 64'(i_plan.n);
        rval = (i_plan.r == '0) ? 64'(R_FULL) : 64'(i_plan.r);
        vco = 64'(i_plan.fout) * 64'(i_plan.p0) * 64'(i_plan.p1);
        // reference times K times 5, compared with pfd limits times 5r
        ref_k = 64'(i_plan.fref) * knum;
        pfd_top = i_plan.holdover ? 64'(HOLD_PFD_MAX_MHZ) : 64'(PFD_MAX_MHZ);
        d.k_ok = 1'b1;
        d.p0_ok = (i_plan.p0 >= P0_MIN) && (i_plan.p0 <= P0_MAX);
        d.p1_ok = i_plan.p1 != '0;
        d.n_ok = nval >= 64'(N_MIN);
        d.vco_ok = (vco >= 64'(VCO_MIN_MHZ) * 64'(HZ_PER_MHZ))
            && (vco <= 64'(VCO_MAX_MHZ) * 64'(HZ_PER_MHZ));
        d.pfd_ok = (ref_k >= 64'(PFD_MIN_HZ) * 64'(K_DENOM) * rval)
            && (ref_k <= pfd_top * 64'(HZ_PER_MHZ) * 64'(K_DENOM) * rval);
        d.exact_ok = (ref_k * nval)
            == (vco * 64'(K_DENOM) * rval);
        d.xo_ok = !i_plan.holdover
            || (ref_k * 64'(i_plan.rxo) == 64'(CRYSTAL_INPUT_MHZ) * 64'h2 * 64'(HZ_PER_MHZ)
                * 64'(K_DENOM) * rval);
        d.legal = d.k_ok && d.p0_ok && d.p1_ok && d.n_ok && d.vco_ok
            && d.pfd_ok && d.exact_ok && d.xo_ok;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
        end
        else if (i_clk_en)
        begin
            q <= d;
        end
    end

    assign o_check = q;

endmodule

// ### pllc_ref_model.sv
// reference sources, crystal and reset driver facing the controller
`timescale 1ns/1ps
module pllc_ref_model
(
    // clock and commands
    input wire logic i_clock,
    input wire logic i_rst_req,
    input wire logic [2:0] i_src_on,
    // pins
    output logic o_reset_pin_n = 1'b1,
    output logic [2:0] o_present = 3'h7
);
    // =====================================================================
    // driver is released at power-up, the pull-up reads high
    always @(posedge i_clock)
    begin
        o_reset_pin_n <= !i_rst_req;
        // bit 2 means a 25 MHz resonator oscillating
        o_present <= i_src_on;
    end
endmodule

// ### pllc_top.sv
// pll divider planning, power-on hold and vco calibration sequencer
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module pllc_top
    import pllc_pkg::*;
#(
    parameter int POR_HOLD_CYCLES = POR_CYCLES,
    parameter int CAL_RUN_CYCLES = CAL_CYCLES
)
(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // device pins
    input wire logic i_reset_pin_n,
    input wire logic i_primary_reference_input_present,
    input wire logic i_secondary_reference_input_present,
    input wire logic i_crystal_input_present,
    input wire logic [3:0] i_input_frequency_select_pins,
    input wire logic [5:0] i_output_frequency_select_pins,
    // status
    output logic o_in_reset,
    output logic o_cal_busy,
    output logic o_cal_fail,
    output logic o_pll_locked,
    output logic o_plan_legal
);

    pllc_core_type q;
    pllc_core_type d;
    pllc_check_type check;
    logic [SYNC_W-1:0] pins_raw;
    logic pin_reset;
    logic ref_any;
    logic [9:0] sel_now;
    logic start_cal;
    logic [TIMER_W-1:0] timer_inc;

    assign pins_raw = {
        i_output_frequency_select_pins,
        i_input_frequency_select_pins,
        i_crystal_input_present,
        i_secondary_reference_input_present,
        i_primary_reference_input_present,
        i_reset_pin_n
    };

    // =====================================================================
    // plan legality
    pllc_plan_check u_check (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_plan(q.plan),
        .o_check(check)
    );

    // =====================================================================
    // next state
    always_comb
    begin
        d = q;
        d.rdata = '0;
        // two-stage pin synchroniser
        d.sync1 = pins_raw;
        d.sync2 = q.sync1;
        pin_reset = !q.sync2[SYNC_RST];
        ref_any = |q.sync2[SYNC_CRYSTAL_INPUT:SYNC_PRIMARY_REFERENCE_INPUT];
        sel_now = q.sync2[SYNC_W-1:SYNC_SEL];
        start_cal = 1'b0;
        timer_inc = q.timer + 16'h0001;

        // -----------------------------------------------------------------
        // register writes
        if (i_wr)
        begin
            if (i_addr == ADDR_CTRL)
            begin
                // two bits cover exactly the four legal scale factors
                d.plan.k_sel = i_wdata[1:0];
                d.plan.holdover = i_wdata[CTRL_HOLD_POS];
            end
            else if (i_addr == ADDR_PDIV)
            begin
                d.plan.p0 = i_wdata[3:0];
                d.plan.p1 = i_wdata[PDIV_P1_POS+5:PDIV_P1_POS];
            end
            else if (i_addr == ADDR_NDIV)
            begin
                d.plan.n = i_wdata[19:0];
            end
            else if (i_addr == ADDR_RDIV)
            begin
                d.plan.r = i_wdata[13:0];
            end
            else if (i_addr == ADDR_XODIV)
            begin
                d.plan.rxo = i_wdata[13:0];
            end
            else if (i_addr == ADDR_FREF)
            begin
                d.plan.fref = i_wdata[29:0];
            end
            else if (i_addr == ADDR_FOUT)
            begin
                d.plan.fout = i_wdata[29:0];
            end
        end

        // -----------------------------------------------------------------
        // register reads, data stand one cycle later
        if (i_rd)
        begin
            if (i_addr == ADDR_CTRL)
            begin
                d.rdata = {29'h0, q.plan.holdover, q.plan.k_sel};
            end
            else if (i_addr == ADDR_PDIV)
            begin
                d.rdata = {18'h0, q.plan.p1, 4'h0, q.plan.p0};
            end
            else if (i_addr == ADDR_NDIV)
            begin
                d.rdata = {12'h0, q.plan.n};
            end
            else if (i_addr == ADDR_RDIV)
            begin
                d.rdata = {18'h0, q.plan.r};
            end
            else if (i_addr == ADDR_XODIV)
            begin
                d.rdata = {18'h0, q.plan.rxo};
            end
            else if (i_addr == ADDR_FREF)
            begin
                d.rdata = {2'h0, q.plan.fref};
            end
            else if (i_addr == ADDR_FOUT)
            begin
                d.rdata = {2'h0, q.plan.fout};
            end
            else if (i_addr == ADDR_STATUS)
            begin
                d.rdata = {
                    8'h0,
                    check.legal,
                    check.xo_ok,
                    check.exact_ok,
                    check.pfd_ok,
                    check.vco_ok,
                    check.n_ok,
                    check.p1_ok,
                    check.p0_ok,
                    5'h0,
                    q.state,
                    q.pins_changed,
                    ref_any,
                    q.in_reset,
                    q.cal_busy,
                    q.cal_fail,
                    q.locked
                };
            end
            else if (i_addr == ADDR_PINS)
            begin
                d.rdata = {12'h0, q.sel_cap, sel_now};
            end
        end

        // -----------------------------------------------------------------
        // select pins moved since calibration: flag only, no rerun
        if (q.cal_busy || q.locked || q.cal_fail)
        begin
            if (sel_now != q.sel_cap)
            begin
                d.pins_changed = 1'b1;
            end
        end

        // -----------------------------------------------------------------
        // calibration sequencer
        case (q.state)
            ST_POR:
            begin
                // power-on hold, extended while the pin holds reset
                if (q.timer >= 16'(POR_HOLD_CYCLES - 1))
                begin
                    if (!pin_reset)
                    begin
                        start_cal = 1'b1;
                    end
                end
                else
                begin
                    d.timer = timer_inc;
                end
            end
            ST_HOLD:
            begin
                if (!pin_reset)
                begin
                    start_cal = 1'b1;
                end
            end
            ST_CAL:
            begin
                d.timer = timer_inc;
                if (!ref_any)
                begin
                    // reference vanished mid-run
                    d.state = ST_FAIL;
                    d.cal_busy = 1'b0;
                    d.cal_fail = 1'b1;
                end
                else if (q.timer >= 16'(CAL_RUN_CYCLES - 1))
                begin
                    d.cal_busy = 1'b0;
                    if (check.legal)
                    begin
                        d.state = ST_LOCK;
                        d.locked = 1'b1;
                    end
                    else
                    begin
                        d.state = ST_FAIL;
                        d.cal_fail = 1'b1;
                    end
                end
            end
            ST_LOCK:
            begin
                d.locked = 1'b1;
            end
            ST_FAIL:
            begin
                // waits for a reset, a late reference changes nothing
                d.cal_fail = 1'b1;
            end
            default:
            begin
                d.state = ST_POR;
                d.timer = '0;
            end
        endcase

        // -----------------------------------------------------------------
        // calibration start
        if (start_cal)
        begin
            d.in_reset = 1'b0;
            d.timer = '0;
            d.sel_cap = sel_now;
            d.pins_changed = 1'b0;
            if (ref_any)
            begin
                d.state = ST_CAL;
                d.cal_busy = 1'b1;
            end
            else
            begin
                d.state = ST_FAIL;
                d.cal_fail = 1'b1;
            end
        end

        // -----------------------------------------------------------------
        // reset pin restarts the sequence and drops any result
        if (pin_reset && (q.state != ST_POR))
        begin
            d.state = ST_HOLD;
            d.timer = '0;
            d.in_reset = 1'b1;
            d.cal_busy = 1'b0;
            d.cal_fail = 1'b0;
            d.locked = 1'b0;
            d.pins_changed = 1'b0;
        end
    end

    // =====================================================================
    // state register, power-on reset restarts from the power-on hold
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            q <= CORE_RESET;
        end
        else if (i_clk_en)
        begin
            q <= d;
        end
    end

    // =====================================================================
    // outputs
    assign o_rdata = q.rdata;
    assign o_in_reset = q.in_reset;
    assign o_cal_busy = q.cal_busy;
    assign o_cal_fail = q.cal_fail;
    assign o_pll_locked = q.locked;
    assign o_plan_legal = check.legal;

endmodule

// ### pllc_top_properties.sv
// port-level assertion checker for the pll planning controller
`timescale 1ns/1ps
module pllc_top_properties
#(
    parameter int POR_HOLD_CYCLES = 20,
    parameter int CAL_RUN_CYCLES = 10
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // device pins
    input wire logic i_reset_pin_n,
    input wire logic i_primary_reference_input_present,
    input wire logic i_secondary_reference_input_present,
    input wire logic i_crystal_input_present,
    // status
    input wire logic o_in_reset,
    input wire logic o_cal_busy,
    input wire logic o_cal_fail,
    input wire logic o_pll_locked,
    input wire logic o_plan_legal
);
    localparam int CAL_MAX = CAL_RUN_CYCLES + 2;
    logic [15:0] por_cnt;
    wire logic any_ref = i_primary_reference_input_present | i_secondary_reference_input_present
        | i_crystal_input_present;

    // =====================================================================
    // edges since power-on release, saturating
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            por_cnt <= 16'h0;
        else if (i_clk_en && por_cnt != 16'hFFFF)
            por_cnt <= por_cnt + 16'h1;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // =====================================================================
    // properties
    property p_por_hold;
        por_cnt < 16'(POR_HOLD_CYCLES - 2) |-> o_in_reset;
    endproperty
    property p_por_end;
        por_cnt == 16'(POR_HOLD_CYCLES + 3) && any_ref |-> !o_in_reset;
    endproperty
    property p_cal_span;
        $rose(o_cal_busy) |-> ##[1:CAL_MAX]
            (!o_cal_busy && (o_pll_locked || o_cal_fail || o_in_reset));
    endproperty
    property p_result_stays;
        (o_cal_fail || o_pll_locked) && i_reset_pin_n && $past(i_reset_pin_n)
            && $past(i_reset_pin_n, 2) && $past(i_reset_pin_n, 3)
            |=> $stable(o_cal_fail) && $stable(o_pll_locked);
    endproperty
    property p_no_ref_fail;
        $fell(o_in_reset) && !any_ref && !$past(any_ref) && !$past(any_ref, 2)
            && !$past(any_ref, 3) |-> ##[0:2] (o_cal_fail && !o_pll_locked);
    endproperty
    property p_lock_legal;
        $rose(o_pll_locked) |-> $past(o_plan_legal);
    endproperty
    property p_pin_reset;
        !i_reset_pin_n [*5] |-> o_in_reset && !o_cal_busy && !o_pll_locked && !o_cal_fail;
    endproperty
    property p_reset_quiet;
        o_in_reset |-> !o_cal_busy && !o_pll_locked && !o_cal_fail;
    endproperty
    property p_excl;
        !(o_pll_locked && o_cal_fail) && !(o_cal_busy && (o_pll_locked || o_cal_fail));
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("in_reset dropped during power-on hold");
    a_por_end: assert property (p_por_end)
        else $error("still in reset after power-on hold");
    a_cal_span: assert property (p_cal_span)
        else $error("calibration did not finish in time");
    a_result_stays: assert property (p_result_stays)
        else $error("calibration result changed without reset");
    a_no_ref_fail: assert property (p_no_ref_fail)
        else $error("calibration without reference did not fail");
    a_lock_legal: assert property (p_lock_legal)
        else $error("locked on an illegal plan");
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin did not clear results");
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("result shown while in reset");
    a_excl: assert property (p_excl)
        else $error("conflicting calibration status");

    c_lock: cover property ($rose(o_pll_locked));
    c_fail: cover property ($rose(o_cal_fail));
    c_pin: cover property ($rose(o_in_reset));
endmodule

// ### tb.sv
// self-checking bench for the pll planning controller
`timescale 1ns/1ps
module tb
    import pllc_pkg::*;
;
    localparam int POR = 20;
    localparam int CAL = 10;
    typedef struct packed {logic [6:0][31:0] regs; logic legal; logic pfd;} pllc_tcase_type;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic rst_req = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [2:0] src_on = 3'h7;
    logic [3:0] sel_in = 4'hB;
    logic [5:0] sel_out = 6'h1C;
    logic [31:0] o_rdata;
    logic pin_n;
    logic [2:0] present;
    logic o_in_reset;
    logic o_cal_busy;
    logic o_cal_fail;
    logic o_pll_locked;
    logic o_plan_legal;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    pllc_tcase_type rows [14];

    always #20 i_clock = ~i_clock;

    pllc_top #(.POR_HOLD_CYCLES(POR), .CAL_RUN_CYCLES(CAL)) i_pllc_top (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_reset_pin_n(pin_n),
        .i_primary_reference_input_present(present[0]),
        .i_secondary_reference_input_present(present[1]),
        .i_crystal_input_present(present[2]), .i_input_frequency_select_pins(sel_in),
        .i_output_frequency_select_pins(sel_out), .o_in_reset(o_in_reset),
        .o_cal_busy(o_cal_busy), .o_cal_fail(o_cal_fail), .o_pll_locked(o_pll_locked),
        .o_plan_legal(o_plan_legal));
    pllc_ref_model i_pllc_ref_model (.i_clock(i_clock), .i_rst_req(rst_req), .i_src_on(src_on),
        .o_reset_pin_n(pin_n), .o_present(present));

    // =====================================================================
    // helpers
    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        tick;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        tick;
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        tick;
        i_rd <= 1'b1;
        i_addr <= a;
        tick;
        i_rd <= 1'b0;
        d = o_rdata;
    endtask
    function automatic pllc_tcase_type mk(input logic [31:0] c, p, n, r, x, f, o,
        input logic lg, pf);
        pllc_tcase_type t;
        t.regs = {o, f, x, r, n, p, c};
        t.legal = lg;
        t.pfd = pf;
        return t;
    endfunction
    // back-to-back writes of the whole plan, then the verdict
    task automatic apply(input pllc_tcase_type c);
        logic [31:0] s;
        tick;
        for (int k = 0; k < 7; k++)
        begin
            i_wr <= 1'b1;
            i_addr <= 4'(k);
            i_wdata <= c.regs[k];
            tick;
        end
        i_wr <= 1'b0;
        repeat (2) tick;
        chk_bit(o_plan_legal, c.legal);
        rd(ADDR_STATUS, s);
        chk_bit(s[23], c.legal);
        chk_bit(s[20], c.pfd);
    endtask
    task automatic pin_reset;
        rst_req <= 1'b1;
        repeat (5) tick;
        chk_bit(o_in_reset, 1'b1);
        chk_bit(o_pll_locked | o_cal_fail | o_cal_busy, 1'b0);
        rst_req <= 1'b0;
    endtask
    task automatic run_cal(output int n);
        n = 0;
        for (int k = 0; k < 12 && o_cal_busy !== 1'b1; k++) tick;
        while (o_cal_busy === 1'b1 && n < 50)
        begin
            n++;
            tick;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            fails++;
            close_out;
        end
    end

    // =====================================================================
    // main sequence
    initial
    begin
        logic [31:0] s;
        int n;
        int t_rel;
        rows[0] = mk(1, 32'h406, 32'h38F40, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 1, 1);
        rows[1] = mk(2, 32'h20B, 32'h14E20, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 1, 1);
        rows[2] = mk(2, 32'h505, 32'hF30, 32'h7D, 32'h32, 32'h7735940, 32'h9450C00, 1, 1);
        rows[3] = mk(2, 32'h405, 32'h7980, 32'h4E2, 32'hC35, 32'h7735940, 32'h9450C00, 0, 1);
        rows[4] = mk(2, 32'h407, 32'h1A940, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 0, 1);
        rows[5] = mk(3, 32'h505, 32'h20, 32'h2, 32'h1, 32'h7735940, 32'h9896800, 0, 0);
        rows[6] = mk(2, 32'h505, 32'h28, 32'h1, 32'h1, 32'h5F5E100, 32'h9896800, 1, 1);
        rows[7] = mk(0, 32'h406, 32'h71E80, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 0, 0);
        rows[8] = mk(5, 32'h406, 32'h38F40, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 1, 1);
        rows[9] = mk(5, 32'h406, 32'h38F40, 32'hC35, 32'hC34, 32'h7735940, 32'h9450C00, 0, 1);
        rows[10] = mk(6, 32'h505, 32'h28, 32'h1, 32'h1, 32'h5F5E100, 32'h9896800, 0, 0);
        rows[11] = mk(1, 32'h604, 32'h38F40, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 0, 1);
        rows[12] = mk(1, 32'h20C, 32'h38F40, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 0, 1);
        rows[13] = mk(1, 32'h406, 32'h38F41, 32'hC35, 32'hC35, 32'h7735940, 32'h9450C00, 0, 1);
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_rel = cyc;
        for (int k = 0; k < 7; k++)
        begin
            rd(4'(k), s);
            chk_word(s, rows[0].regs[k]);
        end
        for (int k = 0; k < 60 && o_in_reset !== 1'b0; k++) tick;
        n = cyc - t_rel;
        chk_bit(n >= POR && n <= POR + 4, 1'b1);
        run_cal(n);
        chk_word(32'(n), 32'(CAL));
        chk_bit(o_pll_locked, 1'b1);
        rd(ADDR_STATUS, s);
        chk_word(s & 32'h7FF, 32'h211);
        rd(ADDR_PINS, s);
        chk_word(s, 32'h72DCB);
        wr(4'h9, 32'hFFFFFFFF);
        rd(4'h9, s);
        chk_word(s, 32'h0);
        for (int i = 0; i < 14; i++) apply(rows[i]);
        apply(rows[0]);
        sel_out <= 6'h1D;
        repeat (6) tick;
        rd(ADDR_STATUS, s);
        chk_bit(s[5], 1'b1);
        chk_bit(o_pll_locked, 1'b1);
        pin_reset;
        run_cal(n);
        chk_word(32'(n), 32'(CAL));
        rd(ADDR_PINS, s);
        chk_word({22'h0, s[19:10]}, 32'h1DB);
        pin_reset;
        for (int k = 0; k < 12 && o_cal_busy !== 1'b1; k++) tick;
        repeat (4) tick;
        pin_reset;
        run_cal(n);
        chk_word(32'(n), 32'(CAL));
        chk_bit(o_pll_locked, 1'b1);
        src_on <= 3'h0;
        pin_reset;
        run_cal(n);
        chk_bit(o_cal_fail & ~o_pll_locked, 1'b1);
        src_on <= 3'h4;
        repeat (30) tick;
        chk_bit(o_cal_fail & ~o_pll_locked, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            src_on <= 3'(1 << i);
            pin_reset;
            run_cal(n);
            chk_word(32'(n), 32'(CAL));
            chk_bit(o_pll_locked, 1'b1);
        end
        src_on <= 3'h7;
        pin_reset;
        for (int k = 0; k < 12 && o_cal_busy !== 1'b1; k++) tick;
        repeat (3) tick;
        src_on <= 3'h0;
        repeat (5) tick;
        chk_bit(o_cal_fail & ~o_pll_locked, 1'b1);
        close_out;
    end
endmodule

bind pllc_top pllc_top_properties #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES),
    .CAL_RUN_CYCLES(CAL_RUN_CYCLES)) i_pllc_top_properties (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_reset_pin_n(i_reset_pin_n),
    .i_primary_reference_input_present(i_primary_reference_input_present),
    .i_secondary_reference_input_present(i_secondary_reference_input_present),
    .i_crystal_input_present(i_crystal_input_present), .o_in_reset(o_in_reset),
    .o_cal_busy(o_cal_busy), .o_cal_fail(o_cal_fail), .o_pll_locked(o_pll_locked),
    .o_plan_legal(o_plan_legal));
